//--- mtc_bus_model.sv
// Behavioural system bus with memory controller seen by the policy unit
`timescale 1ns/100ps
`default_nettype none
`include "mtc_consts.svh"
// ==========================================================================
// Bus partner
module mtc_bus_model #(
  parameter int WORDS = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Pacing from the bench
  input wire logic stall,
  // System bus
  input wire logic busValid,
  input wire logic [2:0] busCmd,
  input wire logic [31:0] busAddr,
  output logic busReady,
  output logic busRvalid,
  output logic [63:0] busRdata
);
  int cmdCnt [8];
  int rdLeft;
  logic [31:0] rdAddr;
  logic beat;
  assign busReady = busValid && !stall && rdLeft == 0;
  assign beat = rdLeft > 0 && !stall;
  always @(posedge clk) begin
    if (!rst_n) begin
      rdLeft <= 0;
      rdAddr <= 32'h0;
      busRvalid <= 1'b0;
      busRdata <= 64'h0;
      foreach (cmdCnt[i]) cmdCnt[i] <= 0;
    end else begin
      if (busValid && busReady) begin
        // Memory counts every accepted command, reads as well as writes and broadcasts
        cmdCnt[busCmd] <= cmdCnt[busCmd] + 1;
        if (busCmd == `MTC_CMD_RD_LINE || busCmd == `MTC_CMD_RD_SINGLE) begin
          rdLeft <= (busCmd == `MTC_CMD_RD_LINE) ? WORDS : 1;
          rdAddr <= busAddr;
        end
      end else if (beat) begin
        rdLeft <= rdLeft - 1;
        rdAddr <= rdAddr + 32'h8;
      end
      busRvalid <= beat;
      // Idle data lines show the inverse of the last value
      busRdata <= beat ? {rdAddr, ~rdAddr} : ~busRdata;
    end
  end
endmodule : mtc_bus_model
`default_nettype wire

//--- mtc_consts.svh
// Offsets, field positions, codes and reset values of the memory type policy unit
`ifndef MTC_CONSTS_SVH
`define MTC_CONSTS_SVH
// Register byte offsets
`define MTC_CTRL_OFFSET 8'h00
`define MTC_STATUS_OFFSET 8'h04
`define MTC_COUNT_OFFSET 8'h08
// Control fields
`define MTC_CTRL_FLUSH_BIT 0
`define MTC_CTRL_SNOOP_EN_BIT 1
`define MTC_CTRL_RESET 32'h0000_0002
// Status fields
`define MTC_STATUS_BUSY_BIT 0
`define MTC_STATUS_WC_ACTIVE_BIT 1
`define MTC_STATUS_WC_FULL_BIT 2
// Effective memory type codes
`define MTC_MT_STRONG 3'h0
`define MTC_MT_WEAK 3'h1
`define MTC_MT_COMBINE 3'h2
`define MTC_MT_WTHRU 3'h3
`define MTC_MT_WBACK 3'h4
`define MTC_MT_WPROT 3'h5
// System bus commands
`define MTC_CMD_RD_SINGLE 3'h0
`define MTC_CMD_WR_SINGLE 3'h1
`define MTC_CMD_RD_LINE 3'h2
`define MTC_CMD_WR_LINE 3'h3
`define MTC_CMD_WR_PARTIAL 3'h4
`define MTC_CMD_WR_INVAL 3'h5
`endif

//--- mtc_pkg.sv
// Types of the memory type policy unit
package mtc_pkg;
  typedef enum logic [2:0] {
    IDLE, DECIDE, WBACK, FILL, SINGLE, FLUSH, DONE
  } mtc_state_type;
endpackage : mtc_pkg

//--- mtc_policy.sv
// Per-access memory type cache policy unit with a small line cache and one combining buffer
`timescale 1ns/100ps
`default_nettype none
`include "mtc_consts.svh"
// ===========================================================================
// Function
// - Strong uncached: no allocation, strict program order
// - Strong uncached: no speculative access at all
// - Weak uncached acts strong; range combining overrides
// - Combining: uncached, no coherency, speculation allowed
// - Combining writes merge in combining buffer
// - Partial combining buffer flushed on serializing events
// - Through and back: read hits cached, misses fill
// - Write through updates line and writes memory
// - Write through never fills invalid line
// - Write back miss fills, then writes in cache
// - Write back data stays dirty until write-back
// - Dirty line written back on eviction or snoop
// - Protected: cached reads, writes broadcast invalidation
// - Speculation allowed except for uncached types
// - Write through keeps memory coherent for non-snoopers
// - Fills are whole aligned lines, never partial
// - Full buffer bursts, else one partial per chunk
// ===========================================================================
module mtc_policy #(
  parameter int LINES = 4,
  parameter int WORDS = 8
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Wishbone slave
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [7:0] wbAdr,
  input wire logic [3:0] wbSel,
  input wire logic [31:0] wbDatW,
  output logic [31:0] wbDatR,
  output logic wbAck,
  // Core access port
  input wire logic coreReq,
  input wire logic coreWe,
  input wire logic coreSpec,
  input wire logic [2:0] coreType,
  input wire logic coreRangeCombine,
  input wire logic [31:0] coreAddr,
  input wire logic [63:0] coreWdata,
  input wire logic [7:0] coreBe,
  input wire logic coreSerialize,
  output logic coreAck,
  output logic coreErr,
  output logic [63:0] coreRdata,
  // System bus master
  output logic busValid,
  output logic [2:0] busCmd,
  output logic [31:0] busAddr,
  output logic [63:0] busWdata,
  output logic [7:0] busBe,
  output logic busLast,
  input wire logic busReady,
  input wire logic busRvalid,
  input wire logic [63:0] busRdata,
  // Snoop port
  input wire logic snoopValid,
  input wire logic [31:0] snoopAddr
);
  localparam int WB = $clog2(WORDS);
  localparam int OFF = WB + 3;
  localparam int IW = $clog2(LINES);
  localparam int TW = 32 - OFF - IW;

  initial begin
    if (LINES < 2 || (1 << IW) != LINES || WORDS < 2 || (1 << WB) != WORDS) begin
      $error("mtc_policy: LINES and WORDS must be powers of two, at least 2");
    end
  end

  // ===========================================================================
  // Storage
  logic [LINES-1:0] validReg;
  logic [LINES-1:0] dirtyReg;
  logic [TW-1:0] tagReg [LINES];
  logic [63:0] dataReg [LINES][WORDS];
  logic [63:0] wcData [WORDS];
  logic [7:0] wcBe [WORDS];
  logic wcActive;
  logic [31-OFF:0] wcLine;
  logic [31:0] ctrlReg;
  logic [31:0] countReg;
  mtc_pkg::mtc_state_type stateReg;
  logic [31:0] reqAddr;
  logic reqWe;
  logic reqSpec;
  logic [2:0] reqType;
  logic [63:0] reqData;
  logic [7:0] reqBe;
  logic reqPending;
  logic snoopWb;
  logic [IW-1:0] vicIdx;
  logic [WB-1:0] beatCnt;
  logic cmdSent;
  logic fillDone;
  logic wbackDone;
  logic flushDone;

  // ===========================================================================
  // Address decode
  logic [IW-1:0] reqIdx;
  logic [TW-1:0] reqTag;
  logic [WB-1:0] reqWord;
  logic reqHit;
  logic [IW-1:0] snIdx;
  logic snHit;
  logic wcFull;
  logic isUncached;
  logic isCacheable;
  logic [2:0] effType;
  logic flushReq;

  assign reqIdx = reqAddr[OFF+IW-1:OFF];
  assign reqTag = reqAddr[31:OFF+IW];
  assign reqWord = reqAddr[OFF-1:3];
  assign reqHit = validReg[reqIdx] && tagReg[reqIdx] == reqTag;
  assign snIdx = snoopAddr[OFF+IW-1:OFF];
  assign snHit = ctrlReg[`MTC_CTRL_SNOOP_EN_BIT] && validReg[snIdx] && tagReg[snIdx] == snoopAddr[31:OFF+IW];
  assign isUncached = reqType == `MTC_MT_STRONG || reqType == `MTC_MT_WEAK;
  assign isCacheable = reqType == `MTC_MT_WTHRU || reqType == `MTC_MT_WBACK || reqType == `MTC_MT_WPROT;
  assign flushReq = coreSerialize || ctrlReg[`MTC_CTRL_FLUSH_BIT];

  always_comb begin
    wcFull = 1'b1;
    for (int i = 0; i < WORDS; i++) begin
      if (wcBe[i] != 8'hFF) begin
        wcFull = 1'b0;
      end
    end
  end

  // Weak uncached taken as combining when the range registers say combining
  always_comb begin
    effType = coreType;
    if (coreType == `MTC_MT_WEAK && coreRangeCombine) begin
      effType = `MTC_MT_COMBINE;
    end
  end

  // ===========================================================================
  // Wishbone registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wbAck <= 1'b0;
      wbDatR <= 32'h0000_0000;
      ctrlReg <= `MTC_CTRL_RESET;
    end else if (ce) begin
      wbAck <= wbCyc && wbStb && !wbAck;
      if (ctrlReg[`MTC_CTRL_FLUSH_BIT] && (stateReg == mtc_pkg::FLUSH || !wcActive)) begin
        ctrlReg[`MTC_CTRL_FLUSH_BIT] <= 1'b0;
      end
      if (wbCyc && wbStb && !wbAck) begin
        wbDatR <= 32'h0000_0000;
        if (wbWe && wbAdr == `MTC_CTRL_OFFSET && wbSel[0]) begin
          ctrlReg[1:0] <= wbDatW[1:0];
        end else if (!wbWe) begin
          unique case (wbAdr)
            `MTC_CTRL_OFFSET: wbDatR <= ctrlReg;
            `MTC_STATUS_OFFSET: wbDatR <= {29'h0, wcFull, wcActive, stateReg != mtc_pkg::IDLE};
            `MTC_COUNT_OFFSET: wbDatR <= countReg;
            default: wbDatR <= 32'h0000_0000;
          endcase
        end
      end
    end
  end

  // ===========================================================================
  // Sequencer and system bus
  logic beatTaken;
  assign beatTaken = busValid && busReady;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stateReg <= mtc_pkg::IDLE;
      busValid <= 1'b0;
      busCmd <= `MTC_CMD_RD_SINGLE;
      busAddr <= 32'h0000_0000;
      busWdata <= 64'h0;
      busBe <= 8'h00;
      busLast <= 1'b0;
      coreAck <= 1'b0;
      coreErr <= 1'b0;
      coreRdata <= 64'h0;
      reqAddr <= 32'h0000_0000;
      reqWe <= 1'b0;
      reqSpec <= 1'b0;
      reqType <= `MTC_MT_STRONG;
      reqData <= 64'h0;
      reqBe <= 8'h00;
      reqPending <= 1'b0;
      snoopWb <= 1'b0;
      vicIdx <= '0;
      beatCnt <= '0;
      cmdSent <= 1'b0;
      countReg <= 32'h0000_0000;
    end else if (ce) begin
      coreAck <= 1'b0;
      if (beatTaken) begin
        busValid <= 1'b0;
        countReg <= countReg + 32'h1;
      end
      unique case (stateReg)
        mtc_pkg::IDLE: begin
          coreErr <= 1'b0;
          if (snoopValid && snHit && dirtyReg[snIdx]) begin
            vicIdx <= snIdx;
            snoopWb <= 1'b1;
            beatCnt <= '0;
            stateReg <= mtc_pkg::WBACK;
          end else if (wcActive && (flushReq || wcFull)) begin
            beatCnt <= '0;
            stateReg <= mtc_pkg::FLUSH;
          end else if (coreReq && !coreAck) begin
            // The request of the access just answered still stands in this cycle
            reqAddr <= coreAddr;
            reqWe <= coreWe;
            reqSpec <= coreSpec;
            reqType <= effType;
            reqData <= coreWdata;
            reqBe <= coreBe;
            reqPending <= 1'b1;
            stateReg <= mtc_pkg::DECIDE;
          end
        end
        mtc_pkg::DECIDE: begin
          beatCnt <= '0;
          cmdSent <= 1'b0;
          if (reqSpec && isUncached) begin
            coreErr <= 1'b1;
            stateReg <= mtc_pkg::DONE;
          end else if (isUncached && wcActive) begin
            stateReg <= mtc_pkg::FLUSH;
          end else if (isUncached || reqType == `MTC_MT_COMBINE) begin
            if (reqType == `MTC_MT_COMBINE && reqWe) begin
              if (wcActive && wcLine != reqAddr[31:OFF]) begin
                stateReg <= mtc_pkg::FLUSH;
              end else begin
                stateReg <= mtc_pkg::DONE;
              end
            end else begin
              stateReg <= mtc_pkg::SINGLE;
            end
          end else if (reqHit) begin
            if (!reqWe) begin
              coreRdata <= dataReg[reqIdx][reqWord];
              stateReg <= mtc_pkg::DONE;
            end else if (reqType == `MTC_MT_WBACK) begin
              stateReg <= mtc_pkg::DONE;
            end else begin
              stateReg <= mtc_pkg::SINGLE;
            end
          end else if (reqWe && reqType != `MTC_MT_WBACK) begin
            stateReg <= mtc_pkg::SINGLE;
          end else begin
            vicIdx <= reqIdx;
            snoopWb <= 1'b0;
            stateReg <= (validReg[reqIdx] && dirtyReg[reqIdx]) ? mtc_pkg::WBACK : mtc_pkg::FILL;
          end
        end
        mtc_pkg::WBACK: begin
          if (!busValid && !wbackDone) begin
            busValid <= 1'b1;
            busCmd <= `MTC_CMD_WR_LINE;
            busAddr <= {tagReg[vicIdx], vicIdx, beatCnt, 3'h0};
            busWdata <= dataReg[vicIdx][beatCnt];
            busBe <= 8'hFF;
            busLast <= beatCnt == WB'(WORDS - 1);
          end
          if (beatTaken) begin
            beatCnt <= beatCnt + WB'(1);
          end
          if (wbackDone) begin
            beatCnt <= '0;
            snoopWb <= 1'b0;
            stateReg <= snoopWb ? mtc_pkg::IDLE : mtc_pkg::FILL;
          end
        end
        mtc_pkg::FILL: begin
          if (!cmdSent && !busValid) begin
            busValid <= 1'b1;
            busCmd <= `MTC_CMD_RD_LINE;
            busAddr <= {reqAddr[31:OFF], {OFF{1'b0}}};
            busBe <= 8'hFF;
            busLast <= 1'b1;
          end
          if (beatTaken) begin
            cmdSent <= 1'b1;
          end
          if (cmdSent && busRvalid) begin
            beatCnt <= beatCnt + WB'(1);
          end
          if (fillDone) begin
            stateReg <= mtc_pkg::DECIDE;
          end
        end
        mtc_pkg::SINGLE: begin
          if (!cmdSent && !busValid) begin
            busValid <= 1'b1;
            busAddr <= reqAddr;
            busWdata <= reqData;
            busBe <= reqWe ? reqBe : 8'hFF;
            busLast <= 1'b1;
            if (!reqWe) begin
              busCmd <= `MTC_CMD_RD_SINGLE;
            end else if (reqType == `MTC_MT_WPROT) begin
              busCmd <= `MTC_CMD_WR_INVAL;
            end else begin
              busCmd <= `MTC_CMD_WR_SINGLE;
            end
          end
          if (beatTaken) begin
            cmdSent <= 1'b1;
            if (reqWe) begin
              stateReg <= mtc_pkg::DONE;
            end
          end
          if (cmdSent && !reqWe && busRvalid) begin
            coreRdata <= busRdata;
            stateReg <= mtc_pkg::DONE;
          end
        end
        mtc_pkg::FLUSH: begin
          if (!busValid && !flushDone) begin
            if (wcFull) begin
              busValid <= 1'b1;
              busCmd <= `MTC_CMD_WR_LINE;
              busBe <= 8'hFF;
              busLast <= beatCnt == WB'(WORDS - 1);
            end else if (wcBe[beatCnt] != 8'h00) begin
              busValid <= 1'b1;
              busCmd <= `MTC_CMD_WR_PARTIAL;
              busBe <= wcBe[beatCnt];
              busLast <= 1'b1;
            end else begin
              beatCnt <= beatCnt + WB'(1);
            end
            busAddr <= {wcLine, beatCnt, 3'h0};
            busWdata <= wcData[beatCnt];
          end
          if (beatTaken) begin
            beatCnt <= beatCnt + WB'(1);
          end
          if (flushDone) begin
            beatCnt <= '0;
            stateReg <= reqPending ? mtc_pkg::DECIDE : mtc_pkg::IDLE;
          end
        end
        mtc_pkg::DONE: begin
          coreAck <= 1'b1;
          reqPending <= 1'b0;
          stateReg <= mtc_pkg::IDLE;
        end
      endcase
    end
  end

  assign wbackDone = stateReg == mtc_pkg::WBACK && beatTaken && busLast;
  assign fillDone = stateReg == mtc_pkg::FILL && cmdSent && busRvalid && beatCnt == WB'(WORDS - 1);
  assign flushDone = stateReg == mtc_pkg::FLUSH && ((beatTaken && beatCnt == WB'(WORDS - 1))
    || (!busValid && !wcFull && wcBe[beatCnt] == 8'h00 && beatCnt == WB'(WORDS - 1)));

  // ===========================================================================
  // Line array
  logic writeHit;
  assign writeHit = stateReg == mtc_pkg::DECIDE && reqWe && reqHit && !(reqSpec && isUncached)
    && (reqType == `MTC_MT_WBACK || reqType == `MTC_MT_WTHRU);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      validReg <= '0;
      dirtyReg <= '0;
    end else if (ce) begin
      if (stateReg == mtc_pkg::IDLE && snoopValid && snHit && !dirtyReg[snIdx]) begin
        validReg[snIdx] <= 1'b0;
      end
      if (wbackDone) begin
        dirtyReg[vicIdx] <= 1'b0;
        if (snoopWb) begin
          validReg[vicIdx] <= 1'b0;
        end
      end
      if (stateReg == mtc_pkg::FILL && cmdSent && busRvalid) begin
        dataReg[reqIdx][beatCnt] <= busRdata;
        validReg[reqIdx] <= 1'b0;
        if (fillDone) begin
          validReg[reqIdx] <= 1'b1;
          dirtyReg[reqIdx] <= 1'b0;
          tagReg[reqIdx] <= reqTag;
        end
      end
      if (writeHit) begin
        for (int b = 0; b < 8; b++) begin
          if (reqBe[b]) begin
            dataReg[reqIdx][reqWord][b*8 +: 8] <= reqData[b*8 +: 8];
          end
        end
        if (reqType == `MTC_MT_WBACK) begin
          dirtyReg[reqIdx] <= 1'b1;
        end
      end
      if (stateReg == mtc_pkg::DECIDE && reqWe && reqHit && reqType == `MTC_MT_WPROT) begin
        validReg[reqIdx] <= 1'b0;
      end
    end
  end

  // ===========================================================================
  // Combining buffer
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wcActive <= 1'b0;
      wcLine <= '0;
      for (int w = 0; w < WORDS; w++) begin
        wcBe[w] <= 8'h00;
        wcData[w] <= 64'h0;
      end
    end else if (ce) begin
      if (flushDone) begin
        wcActive <= 1'b0;
        for (int w = 0; w < WORDS; w++) begin
          wcBe[w] <= 8'h00;
        end
      end else if (stateReg == mtc_pkg::DECIDE && reqWe && reqType == `MTC_MT_COMBINE
                   && !(wcActive && wcLine != reqAddr[31:OFF])) begin
        wcActive <= 1'b1;
        wcLine <= reqAddr[31:OFF];
        for (int b = 0; b < 8; b++) begin
          if (reqBe[b]) begin
            wcData[reqWord][b*8 +: 8] <= reqData[b*8 +: 8];
          end
        end
        wcBe[reqWord] <= wcBe[reqWord] | reqBe;
      end
    end
  end
endmodule : mtc_policy
`default_nettype wire

//--- mtc_policy_props.sv
// Concurrent checks on the ports of the memory type policy unit
`timescale 1ns/100ps
`default_nettype none
`include "mtc_consts.svh"
// ==========================================================================
// Checker
module mtc_policy_props (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register bus
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbAck,
  // Core side
  input wire logic coreReq,
  input wire logic coreWe,
  input wire logic coreSpec,
  input wire logic [2:0] coreType,
  input wire logic coreRangeCombine,
  input wire logic coreAck,
  input wire logic coreErr,
  // System bus
  input wire logic busValid,
  input wire logic [2:0] busCmd,
  input wire logic [31:0] busAddr,
  input wire logic [7:0] busBe,
  input wire logic busReady
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // Uncached kinds that may never be touched speculatively
  logic noSpec;
  assign noSpec = coreType == `MTC_MT_STRONG || (coreType == `MTC_MT_WEAK && !coreRangeCombine);
  sequence sWbReq;
    wbCyc && wbStb && !wbAck;
  endsequence
  sequence sAckPulse;
    wbAck ##1 !wbAck;
  endsequence
  sequence sBeat;
    busValid && busReady;
  endsequence
  chk_wb_answer: assert property (sWbReq |=> sAckPulse)
    else $error("register bus answer not a single pulse");
  chk_refuse_cause: assert property (coreAck && coreErr |-> coreSpec && noSpec)
    else $error("refusal without speculative uncached access");
  chk_spec_blocked: assert property (coreAck && coreSpec && noSpec |-> coreErr)
    else $error("speculative uncached access not refused");
  chk_bus_hold: assert property (busValid && !busReady |=> busValid && $stable(busAddr) && $stable(busCmd))
    else $error("bus request changed before acceptance");
  chk_beat_gap: assert property (sBeat |=> !busValid)
    else $error("bus valid not dropped after a beat");
  chk_fill_align: assert property (busValid && busCmd == `MTC_CMD_RD_LINE |-> busAddr[5:0] == 6'h00)
    else $error("line fill not aligned");
  chk_strong_noline: assert property (coreReq && coreType == `MTC_MT_STRONG && busValid |-> busCmd != `MTC_CMD_RD_LINE)
    else $error("strong uncached access allocated a line");
  chk_prot_inval: assert property (coreReq && coreWe && coreType == `MTC_MT_WPROT && busValid
    |-> busCmd == `MTC_CMD_WR_INVAL)
    else $error("protected write without invalidation broadcast");
  chk_core_pulse: assert property (coreAck |=> !coreAck)
    else $error("core acknowledge longer than one cycle");
  chk_line_lanes: assert property (busValid && busCmd == `MTC_CMD_WR_LINE |-> busBe == 8'hFF)
    else $error("line write beat without all byte lanes");
endmodule : mtc_policy_props
bind mtc_policy mtc_policy_props u_props (.clk, .rst_n, .wbCyc, .wbStb, .wbAck, .coreReq, .coreWe, .coreSpec,
  .coreType, .coreRangeCombine, .coreAck, .coreErr, .busValid, .busCmd, .busAddr, .busBe, .busReady);
`default_nettype wire

//--- mtc_tb.sv
// Self-checking bench for the memory type policy unit
`timescale 1ns/100ps
`default_nettype none
`include "mtc_consts.svh"
// ==========================================================================
// Bench
module testbench;
  typedef struct {
    logic [2:0] typ; logic we; logic spec; logic rc; logic [31:0] addr; logic err; logic [2:0] cmd; int n; int tot;
  } mtc_row_type;
  logic clk, rst_n, ce, wbCyc, wbStb, wbWe, wbAck, coreReq, coreWe, coreSpec, coreRangeCombine, coreSerialize;
  logic coreAck, coreErr, busValid, busReady, busRvalid, snoopValid, stall, slow, e;
  logic [7:0] wbAdr, coreBe;
  logic [3:0] wbSel;
  logic [31:0] wbDatW, wbDatR, coreAddr, busAddr, snoopAddr, q;
  logic [63:0] coreWdata, coreRdata, busRdata, rd;
  logic [2:0] coreType, busCmd;
  int fails, samplesChecked, c0, t0;
  mtc_row_type rows [14] = '{
    '{`MTC_MT_STRONG, 0, 0, 0, 32'h40, 0, `MTC_CMD_RD_SINGLE, 1, 1},
    '{`MTC_MT_STRONG, 0, 1, 0, 32'h48, 1, `MTC_CMD_RD_SINGLE, 0, 0},
    '{`MTC_MT_WEAK, 0, 1, 0, 32'h50, 1, `MTC_CMD_RD_SINGLE, 0, 0},
    '{`MTC_MT_WEAK, 1, 0, 1, 32'h580, 0, `MTC_CMD_WR_PARTIAL, 0, 0},
    '{`MTC_MT_STRONG, 1, 0, 0, 32'h58, 0, `MTC_CMD_WR_PARTIAL, 1, 2},
    '{`MTC_MT_WBACK, 0, 0, 0, 32'h100, 0, `MTC_CMD_RD_LINE, 1, 1},
    '{`MTC_MT_WBACK, 0, 1, 0, 32'h108, 0, `MTC_CMD_RD_LINE, 0, 0},
    '{`MTC_MT_WBACK, 1, 0, 0, 32'h110, 0, `MTC_CMD_WR_SINGLE, 0, 0},
    '{`MTC_MT_WTHRU, 0, 0, 0, 32'h240, 0, `MTC_CMD_RD_LINE, 1, 1},
    '{`MTC_MT_WTHRU, 1, 0, 0, 32'h248, 0, `MTC_CMD_WR_SINGLE, 1, 1},
    '{`MTC_MT_WTHRU, 1, 0, 0, 32'h3C0, 0, `MTC_CMD_WR_SINGLE, 1, 1},
    '{`MTC_MT_WPROT, 1, 0, 0, 32'h4C0, 0, `MTC_CMD_WR_INVAL, 1, 1},
    '{`MTC_MT_WPROT, 0, 1, 0, 32'h488, 0, `MTC_CMD_RD_LINE, 1, 1},
    '{`MTC_MT_COMBINE, 0, 1, 0, 32'h500, 0, `MTC_CMD_RD_SINGLE, 1, 1}
  };
  mtc_policy #(.LINES(4), .WORDS(8)) dut (.clk, .rst_n, .ce, .wbCyc, .wbStb, .wbWe, .wbAdr, .wbSel, .wbDatW,
    .wbDatR, .wbAck, .coreReq, .coreWe, .coreSpec, .coreType, .coreRangeCombine, .coreAddr, .coreWdata, .coreBe,
    .coreSerialize, .coreAck, .coreErr, .coreRdata, .busValid, .busCmd, .busAddr, .busWdata(), .busBe(),
    .busLast(), .busReady, .busRvalid, .busRdata, .snoopValid, .snoopAddr);
  mtc_bus_model #(.WORDS(8)) bus (.clk, .rst_n, .stall, .busValid, .busCmd, .busAddr, .busReady, .busRvalid,
    .busRdata);
  always #10 clk = ~clk;
  always @(posedge clk) stall <= slow & ~stall;
  function automatic int total();
    total = 0;
    foreach (bus.cmdCnt[k]) total += bus.cmdCnt[k];
  endfunction : total
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= w;
    wbAdr <= a;
    wbDatW <= d;
    do @(posedge clk); while (wbAck !== 1'b1);
    q = wbDatR;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
  endtask : wb_xfer
  task automatic access(input logic [2:0] t, input logic w, s, r, input logic [31:0] a, input logic [7:0] be);
    @(posedge clk);
    coreReq <= 1'b1;
    coreType <= t;
    coreWe <= w;
    coreSpec <= s;
    coreRangeCombine <= r;
    coreAddr <= a;
    coreBe <= be;
    coreWdata <= {a, ~a};
    do @(posedge clk); while (coreAck !== 1'b1);
    rd = coreRdata;
    e = coreErr;
    coreReq <= 1'b0;
  endtask : access
  task automatic expect_cnt(input logic [2:0] c, input int base, input int n);
    for (int k = 0; k < 400 && bus.cmdCnt[c] - base < n; k++) @(posedge clk);
    check(64'(bus.cmdCnt[c] - base), 64'(n));
  endtask : expect_cnt
  task automatic end_of_test();
    $display("Mismatches %0d, comparisons %0d", fails, samplesChecked);
    if (fails == 0 && samplesChecked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_of_test
  initial begin
    #600000;
    fails++;
    end_of_test();
  end
  initial begin
    {clk, wbCyc, wbStb, wbWe, coreReq, coreWe, coreSpec, coreRangeCombine, coreSerialize, snoopValid} = '0;
    {rst_n, stall, slow, wbAdr, wbDatW, coreAddr, coreWdata, coreType, snoopAddr} = '0;
    ce = 1'b1;
    wbSel = 4'hF;
    coreBe = 8'hFF;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    wb_xfer(1'b0, `MTC_CTRL_OFFSET, 32'h0);
    check(64'(q), 64'(`MTC_CTRL_RESET));
    wb_xfer(1'b1, `MTC_STATUS_OFFSET, 32'hFFFF_FFFF);
    wb_xfer(1'b0, 8'h0C, 32'h0);
    check(64'(q), 64'h0);
    foreach (rows[i]) begin
      slow <= i[0];
      t0 = total();
      c0 = bus.cmdCnt[rows[i].cmd];
      access(rows[i].typ, rows[i].we, rows[i].spec, rows[i].rc, rows[i].addr, 8'hFF);
      check(64'(e), 64'(rows[i].err));
      check(64'(bus.cmdCnt[rows[i].cmd] - c0), 64'(rows[i].n));
      check(64'(total() - t0), 64'(rows[i].tot));
      if (!rows[i].we && !rows[i].err) check(rd, {rows[i].addr, ~rows[i].addr});
    end
    c0 = bus.cmdCnt[`MTC_CMD_WR_LINE];
    for (int k = 0; k < 8; k++) access(`MTC_MT_COMBINE, 1'b1, 1'b0, 1'b0, 32'h600 + 32'(k * 8), 8'hFF);
    expect_cnt(`MTC_CMD_WR_LINE, c0, 8);
    c0 = bus.cmdCnt[`MTC_CMD_WR_PARTIAL];
    access(`MTC_MT_COMBINE, 1'b1, 1'b0, 1'b0, 32'h700, 8'h0F);
    access(`MTC_MT_COMBINE, 1'b1, 1'b0, 1'b0, 32'h710, 8'hF0);
    check(64'(bus.cmdCnt[`MTC_CMD_WR_PARTIAL] - c0), 64'h0);
    coreSerialize <= 1'b1;
    repeat (2) @(posedge clk);
    coreSerialize <= 1'b0;
    expect_cnt(`MTC_CMD_WR_PARTIAL, c0, 2);
    c0 = bus.cmdCnt[`MTC_CMD_WR_LINE];
    for (int k = 0; k < 5; k++) access(`MTC_MT_WBACK, 1'b0, 1'b0, 1'b0, 32'h1000 + 32'(k * 64), 8'hFF);
    check(64'(bus.cmdCnt[`MTC_CMD_WR_LINE] - c0), 64'h8);
    t0 = bus.cmdCnt[`MTC_CMD_RD_LINE];
    access(`MTC_MT_WBACK, 1'b1, 1'b0, 1'b0, 32'h2000, 8'hFF);
    check(64'(bus.cmdCnt[`MTC_CMD_RD_LINE] - t0), 64'h1);
    c0 = bus.cmdCnt[`MTC_CMD_WR_LINE];
    snoopAddr <= 32'h2000;
    snoopValid <= 1'b1;
    expect_cnt(`MTC_CMD_WR_LINE, c0, 8);
    snoopValid <= 1'b0;
    repeat (20) @(posedge clk);
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
